// ---- hw/fl_regs.svh ----
`ifndef FL_REGS_SVH
`define FL_REGS_SVH

// command opcodes
`define FL_OP_WR_ENABLE   8'h06
`define FL_OP_WR_DISABLE  8'h04
`define FL_OP_WR_REGS     8'h01
`define FL_OP_RD_STATUS   8'h05
`define FL_OP_RD_CONFIG   8'h35
`define FL_OP_PAGE_PROG   8'h02
`define FL_OP_QUAD_PROG   8'h32

// status and configuration field positions
`define FL_SR_LOCK_BIT    7
`define FL_SR_LEVEL_HI    4
`define FL_SR_LEVEL_LO    2
`define FL_SR_WR_LATCH    1
`define FL_SR_BUSY        0
`define FL_CR_QUAD_BIT    1
`define FL_REG_RESET      8'h00

// frame layout in bits
`define FL_OP_BITS        6'd8
`define FL_HDR_BITS       6'd32

// timing
`define FL_CLK_MHZ                 50
`define FL_PAGE_PROGRAM_TIME_NS    700000
`define FL_REG_WRITE_TIME_NS       100000
`define FL_TMR_W                   20

`endif

// ---- hw/fl_pkg.sv ----
`include "fl_regs.svh"

package fl_pkg;

    typedef enum logic [1:0]
    {
        FL_IDLE  = 2'b00,
        FL_READ  = 2'b01,
        FL_WRITE = 2'b10,
        FL_WAIT  = 2'b11
    } fl_phase_e;

    // state on the system clock
    typedef struct packed {
        logic [1:0]            cs_sync;
        logic                  cs_prev;
        logic [1:0]            wp_sync;
        logic [1:0]            tog_sync;
        logic                  tog_seen;
        logic                  register_write_lock_bit;
        logic [2:0]            protect_level;
        logic                  write_enable_latch;
        logic                  write_in_progress_flag;
        logic [7:0]            config_reg;
        logic                  hardware_protected_mode;
        fl_phase_e             phase;
        logic [15:0]           page;
        logic [8:0]            idx;
        logic [`FL_TMR_W-1:0]  timer;
        logic [23:0]           mem_addr;
        logic                  mem_rd;
        logic                  mem_wr;
        logic [7:0]            mem_wdata;
        logic [7:0]            status_out;
        logic [7:0]            config_out;
    } fl_core_s;

    // state on the serial clock
    typedef struct packed {
        logic [5:0]   hdr_cnt;
        logic [7:0]   shift;
        logic [7:0]   opcode;
        logic [23:0]  addr;
        logic [2:0]   dbits;
        logic [1:0]   dbytes;
        logic [7:0]   wptr;
        logic [7:0]   reg_byte0;
        logic [7:0]   reg_byte1;
        logic         armed;
        logic         frame_tog;
        logic [1:0]   busy_sync;
        logic [15:0]  regs_s1;
        logic [15:0]  regs_s2;
    } fl_link_s;

endpackage

// ---- hw/fl_flash_ctrl.sv ----
// Overview of operation
// - hardware protection needs write-protect pin low and lock bit set together.
// - protection enters when the later of pin low and lock bit set arrives, in either order.
// - only raising the write-protect pin leaves hardware protection.
// - under hardware protection lock, level and configuration bits are frozen.
// - outside protection registers are writable once the write latch is set.
// - protection guards only registers; unprotected array stays programmable.
// - quad enable turns the pin into data line two and disables protection.
// - status and configuration registers start at zero.
// - programming only clears bits and requires the write latch set first.
// - data past page end wraps to the page's first byte.
// - beyond 256 bytes only the last 256 received are programmed.
// - fewer bytes program only their own locations, rest of page untouched.
// - select must rise on a whole data byte or the command is dropped.
// - programming starts at select rise and runs self-timed.
// - busy flag reads one for the whole operation then returns to zero.
// - write latch is cleared at program start, and when a register write completes.
// - a program into a level-protected page is not executed.
// - quad program needs quad enable and the write latch both set.
// - quad data moves four bits per clock over the four data lines.
// - quad program otherwise behaves exactly like single-line program.
// - register-write commands are ignored under hardware protection.
// - busy flag is internal, read-only, set during register write or program.
`timescale 1ns/100ps
`include "fl_regs.svh"

module fl_flash_ctrl #(
    parameter int PROG_CYC = (`FL_PAGE_PROGRAM_TIME_NS * `FL_CLK_MHZ + 999) / 1000,
    parameter int REGW_CYC = (`FL_REG_WRITE_TIME_NS * `FL_CLK_MHZ + 999) / 1000
) (
    input  wire logic        clk,        // system clock
    input  wire logic        rst,        // reset, high; synchronous on clk, asynchronous on the serial clock side
    input  wire logic        sck,        // serial clock from host
    input  wire logic        cs_n,       // chip select, low active
    input  wire logic [3:0]  io_in,      // data lines in, line 2 is the protect pin
    output logic             io1_out,    // serial data out
    output logic             io1_oe,     // high while driving line 1
    output logic [23:0]      mem_addr,   // array byte address
    output logic             mem_rd,     // array read strobe
    output logic             mem_wr,     // array write strobe
    output logic [7:0]       mem_wdata,  // array write data
    input  wire logic [7:0]  mem_rdata,  // array read data, same cycle as mem_rd
    output logic [7:0]       status_o,   // status register
    output logic [7:0]       config_o,   // configuration register
    output logic             hw_protect, // hardware protection active
    output logic             busy        // operation in progress
);

    if (PROG_CYC < 1 || PROG_CYC >= (1 << `FL_TMR_W) ||
        REGW_CYC < 1 || REGW_CYC >= (1 << `FL_TMR_W))
    begin : g_chk
        $error("fl_flash_ctrl: timer counts out of range");
    end

    localparam logic [`FL_TMR_W-1:0] PROG_LOAD = `FL_TMR_W'(PROG_CYC - 1);
    localparam logic [`FL_TMR_W-1:0] REGW_LOAD = `FL_TMR_W'(REGW_CYC - 1);

    fl_pkg::fl_core_s core_r;
    fl_pkg::fl_core_s core_nxt;
    fl_pkg::fl_link_s link_r;
    fl_pkg::fl_link_s link_nxt;

    logic [7:0]  page_buf [0:255];
    logic [255:0] page_valid;
    logic        frame_first;
    logic        lk_wr;
    logic        lk_clr;
    logic [7:0]  lk_byte;
    logic [7:0]  lk_idx;
    logic        cs_rise;

    function automatic logic is_prog(input logic [7:0] op);
        is_prog = (op == `FL_OP_PAGE_PROG) || (op == `FL_OP_QUAD_PROG);
    endfunction

    // level L protects the top 2^(L-1) 64 KB regions
    function automatic logic level_hit(input logic [2:0] lvl, input logic [7:0] region);
        level_hit = (lvl != 3'd0) && ({1'b0, ~region} < (9'h001 << (lvl - 3'd1)));
    endfunction

    // ---------------- serial clock domain ----------------

    // set asynchronously while deselected, cleared by the frame's first edge
    always_ff @(posedge sck or posedge cs_n or posedge rst)
    begin
        if (cs_n || rst)
            frame_first <= 1'b1;
        else
            frame_first <= 1'b0;
    end

    always_comb
    begin
        logic [5:0] hdr_len;
        logic       quad_data;
        hdr_len   = is_prog(link_r.opcode) ? `FL_HDR_BITS : `FL_OP_BITS;
        quad_data = (link_r.opcode == `FL_OP_QUAD_PROG);
        link_nxt  = link_r;
        lk_wr     = 1'b0;
        lk_clr    = 1'b0;
        lk_byte   = 8'h00;
        lk_idx    = link_r.wptr;
        link_nxt.busy_sync = {link_r.busy_sync[0], core_r.write_in_progress_flag};
        link_nxt.regs_s1   = {core_r.status_out, core_r.config_out};
        link_nxt.regs_s2   = link_r.regs_s1;
        if (frame_first)
        begin
            link_nxt.frame_tog = ~link_r.frame_tog;
            link_nxt.hdr_cnt   = 6'd1;
            link_nxt.shift     = {7'h00, io_in[0]};
            link_nxt.opcode    = 8'h00;
            link_nxt.dbits     = 3'd0;
            link_nxt.dbytes    = 2'd0;
            link_nxt.armed     = 1'b0;
        end
        else if (link_r.hdr_cnt < hdr_len)
        begin
            link_nxt.hdr_cnt = link_r.hdr_cnt + 6'd1;
            link_nxt.shift   = {link_r.shift[6:0], io_in[0]};
            if (link_r.hdr_cnt == `FL_OP_BITS - 6'd1)
            begin
                link_nxt.opcode = link_nxt.shift;
                // buffer is reused only when the core is not draining it
                if (is_prog(link_nxt.shift) && !link_r.busy_sync[1])
                begin
                    link_nxt.armed = 1'b1;
                    lk_clr         = 1'b1;
                end
            end
            else
            begin
                link_nxt.addr = {link_r.addr[22:0], io_in[0]};
                link_nxt.wptr = link_nxt.addr[7:0];
            end
        end
        else
        begin
            if (quad_data)
            begin
                link_nxt.shift = {link_r.shift[3:0], io_in[3:0]};
                link_nxt.dbits = link_r.dbits + 3'd4;
            end
            else
            begin
                link_nxt.shift = {link_r.shift[6:0], io_in[0]};
                link_nxt.dbits = link_r.dbits + 3'd1;
            end
            if (link_nxt.dbits == 3'd0)
            begin
                if (link_r.dbytes != 2'd3)
                    link_nxt.dbytes = link_r.dbytes + 2'd1;
                if (is_prog(link_r.opcode) && link_r.armed)
                begin
                    lk_wr         = 1'b1;
                    lk_byte       = link_nxt.shift;
                    link_nxt.wptr = link_r.wptr + 8'd1;
                end
                if (link_r.opcode == `FL_OP_WR_REGS && link_r.dbytes == 2'd0)
                    link_nxt.reg_byte0 = link_nxt.shift;
                if (link_r.opcode == `FL_OP_WR_REGS && link_r.dbytes == 2'd1)
                    link_nxt.reg_byte1 = link_nxt.shift;
            end
        end
    end

    always_ff @(posedge sck or posedge rst)
    begin
        if (rst)
            link_r <= '0;
        else
            link_r <= link_nxt;
    end

    // later bytes overwrite earlier ones at the same index
    always_ff @(posedge sck)
    begin
        if (lk_clr)
            page_valid <= '0;
        else if (lk_wr)
            page_valid[lk_idx] <= 1'b1;
        if (lk_wr)
            page_buf[lk_idx] <= lk_byte;
    end

    // register readout shifted on the falling edge
    always_ff @(negedge sck or posedge cs_n or posedge rst)
    begin
        if (cs_n || rst)
        begin
            io1_out <= 1'b0;
            io1_oe  <= 1'b0;
        end
        else if (link_r.hdr_cnt == `FL_OP_BITS && link_r.opcode == `FL_OP_RD_STATUS)
        begin
            io1_out <= link_r.regs_s2[15 - link_r.dbits];
            io1_oe  <= 1'b1;
        end
        else if (link_r.hdr_cnt == `FL_OP_BITS && link_r.opcode == `FL_OP_RD_CONFIG)
        begin
            io1_out <= link_r.regs_s2[7 - link_r.dbits];
            io1_oe  <= 1'b1;
        end
        else
        begin
            io1_out <= 1'b0;
            io1_oe  <= 1'b0;
        end
    end

    // ---------------- system clock domain ----------------

    assign cs_rise = core_r.cs_sync[1] && !core_r.cs_prev;

    always_comb
    begin
        logic new_frame;
        logic byte_ok;
        logic quad_on;
        core_nxt          = core_r;
        new_frame         = (core_r.tog_sync[1] != core_r.tog_seen);
        byte_ok           = (link_r.dbits == 3'd0);
        quad_on           = core_r.config_reg[`FL_CR_QUAD_BIT];
        core_nxt.cs_sync  = {core_r.cs_sync[0], cs_n};
        core_nxt.cs_prev  = core_r.cs_sync[1];
        core_nxt.wp_sync  = {core_r.wp_sync[0], io_in[2]};
        core_nxt.tog_sync = {core_r.tog_sync[0], link_r.frame_tog};
        core_nxt.mem_rd   = 1'b0;
        core_nxt.mem_wr   = 1'b0;
        if (cs_rise)
            core_nxt.tog_seen = core_r.tog_sync[1];
        // link fields are still by now: the serial clock stops with the frame
        case (core_r.phase)
            fl_pkg::FL_IDLE:
            begin
                if (cs_rise && new_frame && link_r.hdr_cnt == `FL_OP_BITS && byte_ok)
                begin
                    if (link_r.opcode == `FL_OP_WR_ENABLE && link_r.dbytes == 2'd0)
                        core_nxt.write_enable_latch = 1'b1;
                    else if (link_r.opcode == `FL_OP_WR_DISABLE && link_r.dbytes == 2'd0)
                        core_nxt.write_enable_latch = 1'b0;
                    else if (link_r.opcode == `FL_OP_WR_REGS && link_r.dbytes != 2'd0 &&
                             link_r.dbytes != 2'd3 && core_r.write_enable_latch &&
                             !core_r.hardware_protected_mode)
                    begin
                        core_nxt.register_write_lock_bit =
                            link_r.reg_byte0[`FL_SR_LOCK_BIT];
                        core_nxt.protect_level =
                            link_r.reg_byte0[`FL_SR_LEVEL_HI:`FL_SR_LEVEL_LO];
                        if (link_r.dbytes == 2'd2)
                            core_nxt.config_reg = link_r.reg_byte1;
                        core_nxt.write_in_progress_flag = 1'b1;
                        core_nxt.timer = REGW_LOAD;
                        core_nxt.phase = fl_pkg::FL_WAIT;
                    end
                end
                if (cs_rise && new_frame && is_prog(link_r.opcode) &&
                    link_r.hdr_cnt == `FL_HDR_BITS && byte_ok && link_r.dbytes != 2'd0 &&
                    link_r.armed && core_r.write_enable_latch &&
                    (link_r.opcode != `FL_OP_QUAD_PROG || quad_on) &&
                    !level_hit(core_r.protect_level, link_r.addr[23:16]))
                begin
                    core_nxt.write_in_progress_flag = 1'b1;
                    core_nxt.write_enable_latch     = 1'b0;
                    core_nxt.page  = link_r.addr[23:8];
                    core_nxt.idx   = 9'd0;
                    core_nxt.phase = fl_pkg::FL_READ;
                end
            end
            fl_pkg::FL_READ:
            begin
                if (core_r.idx[8])
                begin
                    core_nxt.timer = PROG_LOAD;
                    core_nxt.phase = fl_pkg::FL_WAIT;
                end
                else if (page_valid[core_r.idx[7:0]])
                begin
                    core_nxt.mem_addr = {core_r.page, core_r.idx[7:0]};
                    core_nxt.mem_rd   = 1'b1;
                    core_nxt.phase    = fl_pkg::FL_WRITE;
                end
                else
                    core_nxt.idx = core_r.idx + 9'd1;
            end
            fl_pkg::FL_WRITE:
            begin
                core_nxt.mem_wdata = mem_rdata & page_buf[core_r.idx[7:0]];
                core_nxt.mem_wr    = 1'b1;
                core_nxt.idx       = core_r.idx + 9'd1;
                core_nxt.phase     = fl_pkg::FL_READ;
            end
            fl_pkg::FL_WAIT:
            begin
                if (core_r.timer == '0)
                begin
                    core_nxt.write_in_progress_flag = 1'b0;
                    core_nxt.write_enable_latch     = 1'b0;
                    core_nxt.phase = fl_pkg::FL_IDLE;
                end
                else
                    core_nxt.timer = core_r.timer - `FL_TMR_W'(1);
            end
            default:
                core_nxt.phase = fl_pkg::FL_IDLE;
        endcase
        // quad mode borrows the pin as data line two
        core_nxt.hardware_protected_mode = core_nxt.register_write_lock_bit &&
            !core_r.wp_sync[1] && !core_nxt.config_reg[`FL_CR_QUAD_BIT];
        core_nxt.status_out = {core_nxt.register_write_lock_bit, 2'b00,
            core_nxt.protect_level, core_nxt.write_enable_latch,
            core_nxt.write_in_progress_flag};
        core_nxt.config_out = core_nxt.config_reg;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            core_r            <= '0;
            core_r.cs_sync    <= 2'b11;
            core_r.cs_prev    <= 1'b1;
            core_r.config_reg <= `FL_REG_RESET;
            core_r.status_out <= `FL_REG_RESET;
            core_r.config_out <= `FL_REG_RESET;
        end
        else
            core_r <= core_nxt;
    end

    assign mem_addr   = core_r.mem_addr;
    assign mem_rd     = core_r.mem_rd;
    assign mem_wr     = core_r.mem_wr;
    assign mem_wdata  = core_r.mem_wdata;
    assign status_o   = core_r.status_out;
    assign config_o   = core_r.config_out;
    assign hw_protect = core_r.hardware_protected_mode;
    assign busy       = core_r.write_in_progress_flag;

    // ---------------- checks ----------------

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_hpm_both_cond: assert property (
        hw_protect |-> $past(core_r.wp_sync[1]) == 1'b0 && core_r.register_write_lock_bit)
        else $error("protection active without both pin low and lock bit");

    chk_hpm_entry_any: assert property (
        (core_r.register_write_lock_bit && !core_r.wp_sync[1] &&
         !core_r.config_reg[`FL_CR_QUAD_BIT]) ##1 !core_r.config_reg[`FL_CR_QUAD_BIT]
        |-> hw_protect || !core_r.register_write_lock_bit)
        else $error("protection not entered with pin low and lock set");

    chk_hpm_lock_held: assert property (
        hw_protect ##1 !core_r.wp_sync[1] |-> core_r.register_write_lock_bit)
        else $error("lock bit cleared while pin still low");

    chk_regs_frozen: assert property (
        hw_protect |=> $stable(core_r.protect_level) && $stable(core_r.config_reg))
        else $error("protected registers changed");

    chk_quad_no_hpm: assert property (
        core_r.config_reg[`FL_CR_QUAD_BIT] |-> !hw_protect)
        else $error("protection active with quad enabled");

    chk_wip_while_busy: assert property (
        core_r.phase != fl_pkg::FL_IDLE |-> busy && status_o[`FL_SR_BUSY])
        else $error("busy flag low during operation");

    chk_wel_cleared: assert property (
        $fell(busy) |-> !status_o[`FL_SR_WR_LATCH])
        else $error("write latch still set after operation");

    chk_prog_only_clears: assert property (
        mem_wr |-> (mem_wdata & ~$past(mem_rdata)) == 8'h00)
        else $error("program set a bit from zero to one");

    chk_prog_in_page: assert property (
        mem_wr |-> mem_addr[23:8] == core_r.page && $past(mem_rd, 1))
        else $error("program left its page");

    chk_start_on_cs: assert property (
        (core_r.phase == fl_pkg::FL_IDLE ##1 core_r.phase == fl_pkg::FL_READ)
        |-> $past(cs_rise) && busy)
        else $error("program started without select rise");

    chk_protect_block: assert property (
        (core_r.phase == fl_pkg::FL_IDLE ##1 core_r.phase == fl_pkg::FL_READ)
        |-> !level_hit(core_r.protect_level, core_r.page[15:8]))
        else $error("program started in protected region");

    cov_hpm_entry: cover property ($rose(hw_protect));
    cov_prog_done: cover property ($fell(busy) ##1 !status_o[`FL_SR_WR_LATCH]);
    cov_quad_prog: cover property (
        core_r.phase == fl_pkg::FL_WRITE && link_r.opcode == `FL_OP_QUAD_PROG);

endmodule

// ---- verification/fl_host_model.sv ----
`timescale 1ns/100ps
module fl_host_model (
    output logic       sck,   // serial clock, still outside frames
    output logic       cs_n,  // chip select, low active
    output logic [3:0] io,    // data lines toward the device
    input  logic       so,    // serial data from the device
    input  logic       so_oe  // device drives the data line
);
    logic wp_n; // level of the protect pin outside quad data
    initial
    begin
        sck = 1'b0;
        cs_n = 1'b1;
        io = 4'h4;
        wp_n = 1'b1;
    end
    task automatic set_wp(input logic v);
        wp_n = v;
        io[2] = v;
    endtask
    task automatic open();
        cs_n = 1'b0; // select held low for the whole frame
        #8;
    endtask
    task automatic shift(input logic [31:0] v, input int n, input bit quad);
        for (int i = n - 1; i >= 0; i -= (quad ? 4 : 1))
        begin
            if (quad)
                io = v[i -: 4]; // top line carries the top bit
            else
                io = {io[3], wp_n, io[1], v[i]}; // msb first
            #7.5 sck = 1'b1;
            #7.5 sck = 1'b0;
        end
    endtask
    // opcode, then one byte sampled half a period after each falling edge
    task automatic read(input logic [7:0] op, output logic [8:0] v);
        v = 9'h100;
        shift(op, 8, 1'b0);
        for (int i = 7; i >= 0; i--)
        begin
            #7.5 v[i] = so;
            v[8] = v[8] & so_oe;
            sck = 1'b1;
            #7.5 sck = 1'b0;
        end
    endtask
    task automatic close();
        #8 cs_n = 1'b1;
        io = ~io; // released lines must not keep the last bit
        io[2] = wp_n;
        #100; // gap of more than four system cycles between frames
    endtask
endmodule

// ---- verification/tb.sv ----
`timescale 1ns/100ps
`include "fl_regs.svh"
module tb;
    logic        clk = 1'b0;
    logic        rst = 1'b0;
    logic        sck, cs_n, io1_out, io1_oe, mem_rd, mem_wr, hw_protect, busy;
    logic [3:0]  io;
    logic [23:0] mem_addr;
    logic [7:0]  mem_wdata, mem_rdata, status_o, config_o;
    logic [7:0]  mem [0:255]; // one page is enough, address bits above 7 unused
    int          err_count = 0, num_checks = 0, wr_count = 0, cycles = 0;
    always #10 clk = ~clk;
    assign mem_rdata = mem[mem_addr[7:0]];
    fl_host_model host (.sck(sck), .cs_n(cs_n), .io(io), .so(io1_out), .so_oe(io1_oe));
    fl_flash_ctrl #(.PROG_CYC(20), .REGW_CYC(10)) uut (.clk(clk), .rst(rst), .sck(sck),
        .cs_n(cs_n), .io_in(io), .io1_out(io1_out), .io1_oe(io1_oe), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .status_o(status_o), .config_o(config_o), .hw_protect(hw_protect), .busy(busy));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (mem_wr === 1'b1)
        begin
            mem[mem_addr[7:0]] <= mem_wdata;
            wr_count <= wr_count + 1;
        end
        if (cycles == 60000)
        begin
            err_count++;
            finish_test();
        end
    end
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_cnt(input int got, input int exp, input string what);
        num_checks++;
        if (got != exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask
    // sampled on the falling edge: a register write keeps busy up for only ten cycles
    task automatic settle(input logic exp_busy);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk8({7'h00, busy}, {7'h00, exp_busy}, "busy after select rise");
        for (int i = 0; i < 3000 && busy !== 1'b0; i++)
            @(negedge clk);
        chk8({7'h00, busy}, 8'h00, "busy cleared");
    endtask
    task automatic rd_chk(input logic [7:0] op, input logic [7:0] exp, input string what);
        logic [8:0] v;
        host.open();
        host.read(op, v);
        host.close();
        chk8(v[7:0], exp, what);
        chk8({7'h00, v[8]}, 8'h01, "line driven during readout");
    endtask
    task automatic cmd(input logic [7:0] op);
        host.open();
        host.shift(op, 8, 1'b0);
        host.close();
    endtask
    task automatic wregs(input int n, input logic [7:0] s, input logic [7:0] c);
        cmd(`FL_OP_WR_ENABLE);
        host.open();
        host.shift(`FL_OP_WR_REGS, 8, 1'b0);
        host.shift((n == 2) ? {s, c} : s, n * 8, 1'b0);
        host.close();
    endtask
    task automatic prog(input logic [7:0] op, input logic [23:0] a, input int n,
                        input logic [7:0] b, input int cut);
        foreach (mem[i]) mem[i] = 8'hff;
        wr_count = 0;
        host.open();
        host.shift(op, 8, 1'b0);
        host.shift(a, 24, 1'b0);
        for (int i = 0; i < n; i++)
            host.shift(8'(b + i + (i >> 8) * 85), 8, op == `FL_OP_QUAD_PROG);
        if (cut > 0)
            host.shift(32'h0, cut, 1'b0);
        host.close();
    endtask
    task automatic t_page();
        prog(`FL_OP_PAGE_PROG, 24'h000010, 2, 8'h11, 0);
        settle(1'b0);
        chk_cnt(wr_count, 0, "program without latch");
        cmd(`FL_OP_WR_ENABLE);
        prog(`FL_OP_PAGE_PROG, 24'h0000fe, 3, 8'ha0, 0);
        rd_chk(`FL_OP_RD_STATUS, 8'h01, "status while programming");
        settle(1'b1);
        chk8(mem[8'hfe], 8'ha0, "first byte");
        chk8(mem[8'h00], 8'ha2, "wrapped byte");
        chk8(mem[8'h01], 8'hff, "untouched byte");
        chk8(status_o, 8'h00, "latch after program");
        cmd(`FL_OP_WR_ENABLE);
        prog(`FL_OP_PAGE_PROG, 24'h00007f, 1, 8'h3c, 0);
        mem[8'h7f] = 8'hf0; // prog clears the page image; the scan reaches 7f much later
        settle(1'b1);
        chk8(mem[8'h7f], 8'h30, "only ones cleared");
        cmd(`FL_OP_WR_ENABLE);
        prog(`FL_OP_PAGE_PROG, 24'h000020, 1, 8'h33, 4);
        settle(1'b0);
        chk_cnt(wr_count, 0, "select rise inside byte");
        chk8(status_o, 8'h02, "latch kept on refusal");
        prog(`FL_OP_PAGE_PROG, 24'h000000, 257, 8'h00, 0);
        settle(1'b1);
        chk_cnt(wr_count, 256, "bytes written of 257");
        chk8(mem[8'h00], 8'h55, "last byte wins");
        chk8(mem[8'h01], 8'h01, "second byte");
    endtask
    task automatic t_protect();
        wregs(1, 8'h9c, 8'h00);
        settle(1'b1);
        chk8(status_o, 8'h9c, "lock with pin high");
        chk8({7'h00, hw_protect}, 8'h00, "lock alone");
        host.set_wp(1'b0);
        repeat (6) @(posedge clk);
        chk8({7'h00, hw_protect}, 8'h01, "pin lowered after lock");
        wregs(2, 8'h00, 8'h02);
        settle(1'b0);
        chk8(status_o & 8'hfc, 8'h9c, "status frozen");
        chk8(config_o, 8'h00, "config frozen");
        prog(`FL_OP_PAGE_PROG, 24'hff0010, 1, 8'hcc, 0);
        settle(1'b0);
        chk_cnt(wr_count, 0, "program into protected page");
        prog(`FL_OP_PAGE_PROG, 24'h000010, 1, 8'hcc, 0);
        settle(1'b1);
        chk8(mem[8'h10], 8'hcc, "unprotected page written");
        host.set_wp(1'b1);
        repeat (6) @(posedge clk);
        chk8({7'h00, hw_protect}, 8'h00, "pin raised");
        wregs(1, 8'h00, 8'h00);
        settle(1'b1);
        chk8(status_o, 8'h00, "writable again");
    endtask
    task automatic t_quad();
        cmd(`FL_OP_WR_ENABLE);
        prog(`FL_OP_QUAD_PROG, 24'h000040, 1, 8'ha5, 0);
        settle(1'b0);
        chk_cnt(wr_count, 0, "quad without quad bit");
        host.set_wp(1'b0);
        wregs(1, 8'h80, 8'h00);
        settle(1'b1);
        chk8({7'h00, hw_protect}, 8'h01, "lock set after pin low");
        host.set_wp(1'b1);
        wregs(2, 8'h80, 8'h02);
        settle(1'b1);
        chk8(config_o, 8'h02, "quad bit set");
        rd_chk(`FL_OP_RD_CONFIG, 8'h02, "config readout");
        host.set_wp(1'b0);
        repeat (6) @(posedge clk);
        chk8({7'h00, hw_protect}, 8'h00, "protection off in quad");
        cmd(`FL_OP_WR_ENABLE);
        prog(`FL_OP_QUAD_PROG, 24'h0000ff, 2, 8'ha5, 0);
        settle(1'b1);
        chk8(mem[8'hff], 8'ha5, "quad byte");
        chk8(mem[8'h00], 8'ha6, "quad wrap");
    endtask
    initial
    begin
        rst <= 1'b1; // a real edge, so the link side is cleared as well
        foreach (mem[i]) mem[i] = 8'hff;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (5) @(posedge clk);
        chk8(status_o, 8'h00, "status after reset");
        chk8(config_o, 8'h00, "config after reset");
        t_page();
        t_protect();
        t_quad();
        finish_test();
    end
endmodule
